// ===== bench/ezwt_mem_model.sv
// far-side memory model that stretches accesses through the ready pin
`timescale 1ns/1ps
module ezwt_mem_model (
    input wire clk_in,
    input wire cs_n_in,
    input wire [3:0] stall_in,
    output wire ready_out
);
    reg [3:0] cnt;
    always @(posedge clk_in) begin
        cnt <= cs_n_in ? 4'h0 : cnt + {3'h0, cnt != 4'hf};
    end
    // pulled up when deselected; low for stall_in cycles once selected
    assign ready_out = cs_n_in | (cnt >= stall_in);
endmodule // ezwt_mem_model

// ===== bench/ezwt_top_sva.sv
// port assertions for the zone wait timing sequencer
`timescale 1ns/1ps
module ezwt_top_sva (
    input wire CLK_IN,
    input wire RST_IN,
    input wire BUSY_OUT,
    input wire DONE_OUT,
    input wire ZONE_CS_N_OUT,
    input wire RD_N_OUT,
    input wire WE_N_OUT,
    input wire RNW_OUT,
    input wire [7:0] WAIT_STATES_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    a_strobe_in_cs: assert property (!(RD_N_OUT && WE_N_OUT)
        |-> !ZONE_CS_N_OUT) else $error("strobe outside select");
    a_busy_cs: assert property (BUSY_OUT |-> !ZONE_CS_N_OUT)
        else $error("busy without select");
    a_busy_done: assert property ($fell(BUSY_OUT) |-> DONE_OUT)
        else $error("access ended without done");
    a_done_once: assert property (DONE_OUT |=> !DONE_OUT)
        else $error("done longer than a cycle");
    a_lead_first: assert property ($fell(RD_N_OUT && WE_N_OUT)
        |-> $past(!ZONE_CS_N_OUT)) else $error("no lead cycle");
    a_trail_last: assert property ($rose(ZONE_CS_N_OUT)
        |-> RD_N_OUT && WE_N_OUT) else $error("strobe held past select");
    a_read_dir: assert property (!RD_N_OUT |-> RNW_OUT)
        else $error("read strobe on a write");
    a_write_dir: assert property (!WE_N_OUT |-> !RNW_OUT)
        else $error("write strobe on a read");
    cover property ($fell(RD_N_OUT));
    cover property ($fell(WE_N_OUT));
    cover property (DONE_OUT && WAIT_STATES_OUT != 8'h00);
endmodule // ezwt_top_sva
bind ezwt_top ezwt_top_sva chk (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
    .BUSY_OUT(BUSY_OUT), .DONE_OUT(DONE_OUT),
    .ZONE_CS_N_OUT(ZONE_CS_N_OUT), .RD_N_OUT(RD_N_OUT),
    .WE_N_OUT(WE_N_OUT), .RNW_OUT(RNW_OUT),
    .WAIT_STATES_OUT(WAIT_STATES_OUT));

// ===== bench/ezwt_top_tb.sv
// self-checking bench for the zone wait timing sequencer
`timescale 1ns/1ps
module ezwt_top_tb;
    reg clk = 0, rst = 1, req = 0, wr = 0, half = 0;
    reg [1:0] zn = 0;
    reg [3:0] stall = 0;
    reg [50:0] tw;
    reg xp;
    integer err_total = 0, num_checks = 0, ld, ac, tr, dirbad;
    wire busy, done, cs_n, rd_n, we_n, rdy, rnw, xclk;
    wire [1:0] ph;
    wire [7:0] ws;
    initial forever #20 clk = ~clk;
    ezwt_top uut (.CLK_IN(clk), .RST_IN(rst), .ZONE_TIMING_IN(tw),
        .HALF_XCLK_IN(half), .REQ_IN(req), .REQ_WRITE_IN(wr),
        .REQ_ZONE_IN(zn), .READY_PIN_IN(rdy), .BUSY_OUT(busy),
        .DONE_OUT(done), .ZONE_CS_N_OUT(cs_n), .RD_N_OUT(rd_n),
        .WE_N_OUT(we_n), .RNW_OUT(rnw), .XCLK_OUT(xclk), .PHASE_OUT(ph),
        .WAIT_STATES_OUT(ws));
    ezwt_mem_model mem (.clk_in(clk), .cs_n_in(cs_n), .stall_in(stall),
        .ready_out(rdy));
    function [16:0] f(input d, e, s, input [1:0] rl, input [2:0] ra,
        input [1:0] rt, wl, input [2:0] wa, input [1:0] wt);
        f = {d, e, s, rl, ra, rt, wl, wa, wt};
    endfunction
    task chk(input string nm, input [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            err_total++;
            $display("mismatch %0s exp %0d saw %0d", nm, e, s);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // measures lead, active and trail lengths while select is low
    task acc(input w, input [1:0] z);
        integer n;
        wr = w;
        zn = z;
        req = 1;
        {ld, ac, tr, n, dirbad} = 0;
        while (busy !== 1'b1 && n < 50) begin
            xp = xclk;
            @(negedge clk);
            n++;
        end
        req = 0;
        // at half rate the start edge must also raise the external clock
        if (half) chk("xclk rise", {xp, xclk}, 2'b01);
        while (done !== 1'b1 && n < 200) begin
            if (!cs_n) begin
                if (rnw !== !w) dirbad++;
                if (!(w ? we_n : rd_n)) ac++;
                else if (ac == 0) ld++;
                else tr++;
            end
            @(negedge clk);
            n++;
        end
        if (n >= 200) begin
            err_total++;
            tally_and_finish;
        end
        chk("direction", dirbad, 0);
        chk("idle direction", rnw, 1);
    endtask
    task run(input w, input [1:0] z, input integer el, ea, et, ew);
        acc(w, z);
        chk("lead", ld, el);
        chk("active", ac, ea + ew);
        chk("trail", tr, et);
        chk("waits", ws, ew);
        chk("last phase", ph, (et != 0) ? 3 : 2);
    endtask
    task t_plain;
        stall = 8;
        run(0, 0, 1, 3, 1, 0);
        run(1, 0, 2, 4, 2, 0);
        run(0, 3, 1, 3, 1, 0);
        $display("test plain done");
    endtask
    task t_dbl;
        half = 1;
        // let the divider settle so the first start lands on its phase
        repeat (2) @(negedge clk);
        run(0, 1, 4, 3, 2, 0);
        run(1, 1, 2, 1, 6, 0);
        half = 0;
        $display("test double done");
    endtask
    task t_rdy;
        // waits = stall + 3 - lead - active (sync) or + 4 (async): the
        // pin is seen two or three cycles late
        run(0, 2, 1, 2, 1, 8);
        run(1, 2, 1, 3, 1, 7);
        stall = 0;
        run(0, 2, 1, 2, 1, 0);
        stall = 8;
        tw[50:34] = f(0, 1, 1, 1, 2, 0, 1, 2, 0);
        run(0, 2, 1, 3, 0, 8);
        run(1, 2, 1, 3, 0, 8);
        $display("test ready done");
    endtask
    task t_bad;
        tw[16:0] = 17'h00000;
        acc(0, 0);
        chk("busy", busy, 0);
        $display("test illegal done");
    endtask
    initial begin
        tw = {f(0, 1, 0, 1, 1, 1, 1, 2, 1), f(1, 0, 0, 2, 1, 1, 1, 0, 3),
            f(0, 0, 0, 1, 2, 1, 2, 3, 2)};
        repeat (16) @(negedge clk);
        rst = 0;
        t_plain;
        t_dbl;
        t_rdy;
        t_bad;
        tally_and_finish;
    end
endmodule // ezwt_top_tb

// ===== common/ezwt_defs.vh
// constants for the external zone wait timing block
`ifndef EZWT_DEFS_VH
`define EZWT_DEFS_VH
`define EZWT_LEAD_W 2
`define EZWT_ACT_W 3
`define EZWT_TRAIL_W 2
// field positions inside one zone timing word
`define EZWT_WR_TRAIL_LSB 0
`define EZWT_WR_ACT_LSB 2
`define EZWT_WR_LEAD_LSB 5
`define EZWT_RD_TRAIL_LSB 7
`define EZWT_RD_ACT_LSB 9
`define EZWT_RD_LEAD_LSB 12
`define EZWT_READY_SYNC_BIT 14
`define EZWT_READY_EN_BIT 15
`define EZWT_DOUBLE_BIT 16
`define EZWT_TIMING_W 17
`define EZWT_TIMING_RESET 17'h1ffff
`define EZWT_ZONES 3
`endif

// ===== hw/ezwt_ready_sync.v
// ready input conditioning: synchroniser plus sync or async sampling
`timescale 1ns/1ps
module ezwt_ready_sync (
    input wire clk_in,
    input wire rst_in,
    input wire ready_pin_in,
    input wire async_mode_in,
    output reg ready_out
);
    reg meta;
    reg sync1;
    reg sync2;
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta <= 1'b0;
            sync1 <= 1'b0;
            sync2 <= 1'b0;
        end else begin
            meta <= ready_pin_in;
            sync1 <= meta;
            sync2 <= sync1;
        end
    end
    // no output register: a shortest legal lead plus active must still see
    // the pin as it stood after select fell, not the idle pull-up level
    // async mode takes one more stage for extra settling margin
    always @* begin
        ready_out = async_mode_in ? sync2 : sync1;
    end
endmodule // ezwt_ready_sync

// ===== hw/ezwt_top.v
// access phase sequencer for the zoned external parallel interface
`timescale 1ns/1ps
`include "ezwt_defs.vh"
// Summary of operation
// R1: each access runs lead, active, trail; a zero trail count ends the access after active
// R2: one timing register word per zone
// R3: read lead is count, doubled if scaled
// R4: read active is count, waits, plus one
// R5: read trail is count, doubled if scaled
// R6: write lead is count, doubled if scaled
// R7: write active is count, waits, plus one
// R8: write trail is count, doubled if scaled
// R9: ready ignored means zero wait states
// R10: illegal settings run unchecked, no error
// R11: ready ignored, synchronous or asynchronous
// R12: host keeps lead at least one
// R13: sync mode host keeps lead, active nonzero
// R14: async mode write active two cycles
// R15: async mode lead plus active at least four
// R16: strobes change on timing clock edge
// R17: external clock full or half, aligned; at full rate XCLK_OUT toggles every cycle and starts ignore its phase
// R18: active stretches until ready seen
// R19: addressed zone and direction pick fields
module ezwt_top #(
    parameter ZONES = `EZWT_ZONES
) (
    input wire CLK_IN,
    input wire RST_IN,
    input wire [`EZWT_TIMING_W*ZONES-1:0] ZONE_TIMING_IN,
    input wire HALF_XCLK_IN,
    input wire REQ_IN,
    input wire REQ_WRITE_IN,
    input wire [1:0] REQ_ZONE_IN,
    input wire READY_PIN_IN,
    output reg BUSY_OUT,
    output reg DONE_OUT,
    output reg ZONE_CS_N_OUT,
    output reg RD_N_OUT,
    output reg WE_N_OUT,
    output reg RNW_OUT,
    output reg XCLK_OUT,
    output reg [1:0] PHASE_OUT,
    output reg [7:0] WAIT_STATES_OUT
);
    localparam ST_IDLE = 2'h0;
    localparam ST_LEAD = 2'h1;
    localparam ST_ACT = 2'h2;
    localparam ST_TRAIL = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // field decode, shared by the start of every phase
    function [4:0] phase_len;
        input [`EZWT_TIMING_W-1:0] t;
        input wr;
        input [1:0] ph;
        reg [2:0] raw;
        begin
            raw = 3'h0;
            case (ph)
                ST_LEAD: raw = wr ? {1'b0, t[`EZWT_WR_LEAD_LSB +: 2]}
                                  : {1'b0, t[`EZWT_RD_LEAD_LSB +: 2]};
                ST_ACT: raw = wr ? t[`EZWT_WR_ACT_LSB +: 3]
                                 : t[`EZWT_RD_ACT_LSB +: 3];
                ST_TRAIL: raw = wr ? {1'b0, t[`EZWT_WR_TRAIL_LSB +: 2]}
                                   : {1'b0, t[`EZWT_RD_TRAIL_LSB +: 2]};
                default: raw = 3'h0;
            endcase
            // doubling applies to the programmed part only
            phase_len = t[`EZWT_DOUBLE_BIT] ? {1'b0, raw, 1'b0}
                                            : {2'h0, raw}; // see R3 R5 R6 R8
            if (ph == ST_ACT)
                phase_len = phase_len + 5'h01; // see R4 R7
        end
    endfunction

    reg [`EZWT_TIMING_W-1:0] cur;
    reg wr;
    reg [1:0] state;
    reg [4:0] cnt;
    reg [1:0] zone_q;
    wire ready_q;
    wire use_ready = cur[`EZWT_READY_EN_BIT];
    wire [`EZWT_TIMING_W-1:0] sel_timing;
    // out-of-range zone falls to zone 0; settings are never checked
    assign sel_timing = (REQ_ZONE_IN < ZONES) ?
        ZONE_TIMING_IN[REQ_ZONE_IN*`EZWT_TIMING_W +: `EZWT_TIMING_W] :
        ZONE_TIMING_IN[`EZWT_TIMING_W-1:0]; // see R2 R19 R10

    ezwt_ready_sync u_ready (
        .clk_in(CLK_IN),
        .rst_in(RST_IN),
        .ready_pin_in(READY_PIN_IN),
        .async_mode_in(cur[`EZWT_READY_SYNC_BIT]),
        .ready_out(ready_q)
    ); // see R11

    ////////////////////////////////////////////////////////////////////////
    // external clock divider; at half rate accesses start only on its rising phase
    reg xclk_phase;
    wire start_ok = !HALF_XCLK_IN || !xclk_phase; // see R17
    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            xclk_phase <= 1'b0;
            XCLK_OUT <= 1'b0;
        end else begin
            xclk_phase <= HALF_XCLK_IN ? ~xclk_phase : 1'b0;
            // full rate is approximated as a level toggling every cycle
            XCLK_OUT <= HALF_XCLK_IN ? ~xclk_phase : ~XCLK_OUT;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // phase sequencer, one count per timing clock
    reg [1:0] next_state;
    reg [4:0] next_len;
    always @* begin
        next_state = state;
        next_len = cnt;
        case (state)
            ST_IDLE: begin
                next_state = ST_LEAD;
                next_len = phase_len(sel_timing, REQ_WRITE_IN, ST_LEAD);
            end
            ST_LEAD: begin
                next_state = ST_ACT;
                next_len = phase_len(cur, wr, ST_ACT);
            end
            ST_ACT: begin
                next_state = ST_TRAIL;
                next_len = phase_len(cur, wr, ST_TRAIL);
            end
            ST_TRAIL: begin
                next_state = ST_IDLE;
                next_len = 5'h00;
            end
            default: begin
                next_state = ST_IDLE;
                next_len = 5'h00;
            end
        endcase
    end

    wire phase_end = (cnt <= 5'h01);
    // a zero trail ends the access with active; a zero lead still costs
    // one cycle, as illegal settings are run as they come
    wire skip_trail = (next_state == ST_TRAIL) && (next_len == 5'h00);
    wire hold_act = (state == ST_ACT) && use_ready && !ready_q; // see R9 R18

    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state <= ST_IDLE;
            cnt <= 5'h00;
            cur <= `EZWT_TIMING_RESET;
            wr <= 1'b0;
            zone_q <= 2'h0;
            BUSY_OUT <= 1'b0;
            DONE_OUT <= 1'b0;
            ZONE_CS_N_OUT <= 1'b1;
            RD_N_OUT <= 1'b1;
            WE_N_OUT <= 1'b1;
            RNW_OUT <= 1'b1;
            PHASE_OUT <= ST_IDLE;
            WAIT_STATES_OUT <= 8'h00;
        end else begin
            DONE_OUT <= 1'b0;
            if (state == ST_IDLE) begin
                if (REQ_IN && start_ok) begin
                    cur <= sel_timing; // see R19
                    wr <= REQ_WRITE_IN;
                    zone_q <= REQ_ZONE_IN;
                    BUSY_OUT <= 1'b1;
                    ZONE_CS_N_OUT <= 1'b0;
                    RNW_OUT <= ~REQ_WRITE_IN;
                    WAIT_STATES_OUT <= 8'h00;
                    cnt <= next_len;
                    state <= ST_LEAD; // see R1
                end
            end else if (cnt != 5'h00 && !phase_end) begin
                cnt <= cnt - 5'h01; // see R16
            end else if (hold_act && cnt <= 5'h01) begin
                // stretch active until ready is sampled high
                WAIT_STATES_OUT <= WAIT_STATES_OUT + 8'h01; // see R18
                cnt <= 5'h01;
            end else begin
                state <= skip_trail ? ST_IDLE : next_state; // see R1
                cnt <= next_len;
                if (next_state == ST_ACT) begin
                    RD_N_OUT <= wr;
                    WE_N_OUT <= ~wr;
                end
                if (next_state == ST_TRAIL) begin
                    RD_N_OUT <= 1'b1;
                    WE_N_OUT <= 1'b1;
                end
                if (next_state == ST_IDLE || skip_trail) begin // see R5 R8
                    ZONE_CS_N_OUT <= 1'b1;
                    RNW_OUT <= 1'b1;
                    BUSY_OUT <= 1'b0;
                    DONE_OUT <= 1'b1;
                end
            end
            PHASE_OUT <= state;
        end
    end
endmodule // ezwt_top
